// ---- cpu_seq_defs.svh ----
// constants for the bus cycle sequencer: opcode fields, reset values
// assumes inclusion by the sequencer package and the sequencer module
`ifndef CPU_SEQ_DEFS_SVH
`define CPU_SEQ_DEFS_SVH

// opcode layout: [7] store, [6:4] mode, [3] index y, [1:0] register
`define OPC_STORE_BIT 7
`define OPC_MODE_MSB 6
`define OPC_MODE_LSB 4
`define OPC_IDX_Y_BIT 3
`define OPC_REG_MSB 1
`define OPC_REG_LSB 0

// mode field codes
`define MODE_IMM 3'h0
`define MODE_ZP 3'h1
`define MODE_ABS 3'h2
`define MODE_IZX 3'h3
`define MODE_ABX 3'h4
`define MODE_ZPX 3'h5
`define MODE_IZY 3'h6

// register select codes for stores
`define REG_SEL_A 2'h0
`define REG_SEL_X 2'h1
`define REG_SEL_Y 2'h2

// reset values
`define RESET_PC 16'h0000
`define PAGE_ZERO 8'h00
`define RESET_DOUT 8'h00
`define RESET_BYTE 8'h00

// address offsets of the fetch pointer
`define PC_STEP 16'h0001
`define ABS_LEN 16'h0003

`endif

// ---- cpu_seq_pkg.sv ----
// types shared by the bus cycle sequencer and its tests
// assumes the defs header sits in the same folder
`include "cpu_seq_defs.svh"

package cpu_seq_pkg;

  // bus cycle slot within one instruction
  typedef enum logic [2:0] {
    ST_FETCH,
    ST_OPND,
    ST_HIGH,
    ST_DUMMY,
    ST_PTR_LO,
    ST_PTR_HI,
    ST_INDEXED,
    ST_DATA
  } cycle_t;

  // addressing modes decoded from the opcode
  typedef enum logic [2:0] {
    AM_IMM,
    AM_ZP,
    AM_ABS,
    AM_IZX,
    AM_ABX,
    AM_ZPX,
    AM_IZY
  } addr_mode_t;

  // everything the sequencer drives onto the system bus
  typedef struct packed {
    logic [15:0] addr;
    logic rw;
    logic [7:0] dout;
    logic doe_n;
  } bus_t;

  // core register values supplied by the datapath
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] x;
    logic [7:0] y;
  } core_regs_t;

  // whole sequencer state
  typedef struct packed {
    cycle_t cyc;
    logic [15:0] pc;
    logic [7:0] opc;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] ptr;
    logic carry;
    logic [7:0] opnd;
    logic opnd_valid;
    bus_t bus;
  } seq_state_t;

  // unused mode codes fall back to the two-cycle immediate form
  function automatic addr_mode_t opc_mode(input logic [7:0] opc);
    addr_mode_t m;
    m = AM_IMM;
    case (opc[`OPC_MODE_MSB:`OPC_MODE_LSB])
      `MODE_ZP: m = AM_ZP;
      `MODE_ABS: m = AM_ABS;
      `MODE_IZX: m = AM_IZX;
      `MODE_ABX: m = AM_ABX;
      `MODE_ZPX: m = AM_ZPX;
      `MODE_IZY: m = AM_IZY;
      default: m = AM_IMM;
    endcase
    return m;
  endfunction : opc_mode

endpackage : cpu_seq_pkg

// ---- index_adder.sv ----
// low-byte index adder with explicit carry out
// assumes a purely combinational use inside the sequencer
`timescale 1ns/1ps

module index_adder (
  input wire logic [7:0] base,
  input wire logic [7:0] index,
  output logic [7:0] sum,
  output logic carry
);

  // nine-bit sum keeps the carry that decides the page fix-up
  logic [8:0] wide;

  always_comb begin
    wide = {1'b0, base} + {1'b0, index};
    sum = wide[7:0];
    carry = wide[8];
  end

endmodule : index_adder

// ---- cpu_bus_cycle_sequencer.sv ----
// cycle-by-cycle bus sequencer for memory-read and store instructions
// assumes memory answers every read in the same cycle on bus_din and
// captures bus.dout in every cycle where bus.rw is low
`timescale 1ns/1ps
`include "cpu_seq_defs.svh"

module cpu_bus_cycle_sequencer
  import cpu_seq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] bus_din,
  input wire core_regs_t regs,
  output bus_t bus,
  output logic opcode_fetch,
  output logic [7:0] operation_code,
  output logic [7:0] operand_data,
  output logic operand_valid
);

  seq_state_t s_q;
  seq_state_t s_d;
  addr_mode_t mode;
  logic is_store;
  logic [7:0] idx;
  logic [7:0] idx_sum;
  logic idx_carry;
  logic [7:0] wdata;
  logic [15:0] pc_next;

  // decode of the opcode held for the running instruction
  always_comb begin
    mode = opc_mode(s_q.opc);
    is_store = s_q.opc[`OPC_STORE_BIT] && (mode != AM_IMM);
  end

  // index source: indirect forms are fixed, the rest pick by opcode bit
  always_comb begin
    case (mode)
      AM_IZX: idx = regs.x;
      AM_IZY: idx = regs.y;
      default: idx = s_q.opc[`OPC_IDX_Y_BIT] ? regs.y : regs.x;
    endcase
  end

  // register that a store drives onto the data bus
  always_comb begin
    case (s_q.opc[`OPC_REG_MSB:`OPC_REG_LSB])
      `REG_SEL_X: wdata = regs.x;
      `REG_SEL_Y: wdata = regs.y;
      default: wdata = regs.a;
    endcase
  end

  // the base low byte is always lo_q, so one adder serves all modes
  index_adder u_index_adder (
    .base(s_q.lo),
    .index(idx),
    .sum(idx_sum),
    .carry(idx_carry)
  );

  assign pc_next = s_q.pc + `PC_STEP;

  // a read cycle releases the data bus
  function automatic bus_t rd_cycle(input logic [15:0] a);
    bus_t b;
    b.addr = a;
    b.rw = 1'b1;
    b.dout = `RESET_DOUT;
    b.doe_n = 1'b1;
    return b;
  endfunction : rd_cycle

  // final memory access: read, or write with the register driven
  function automatic bus_t mem_cycle(input logic [15:0] a,
                                     input logic wr,
                                     input logic [7:0] d);
    bus_t b;
    b.addr = a;
    b.rw = !wr;
    b.dout = wr ? d : `RESET_DOUT;
    b.doe_n = !wr;
    return b;
  endfunction : mem_cycle

  // next-state logic; bus fields describe the cycle that follows
  always_comb begin
    s_d = s_q;
    s_d.opnd_valid = 1'b0;
    case (s_q.cyc)
      ST_FETCH: begin
        // opcode read at pc, step pc to the first operand byte
        s_d.opc = bus_din;
        s_d.pc = pc_next;
        s_d.cyc = ST_OPND;
        s_d.bus = rd_cycle(pc_next);
      end
      ST_OPND: begin
        s_d.pc = pc_next;
        s_d.lo = bus_din;
        case (mode)
          AM_ZP: begin
            s_d.cyc = ST_DATA;
            s_d.bus = mem_cycle({`PAGE_ZERO, bus_din}, is_store,
                                wdata);
          end
          AM_ABS, AM_ABX: begin
            s_d.cyc = ST_HIGH;
            s_d.bus = rd_cycle(pc_next);
          end
          AM_IZX, AM_ZPX: begin
            // discarded read at the unindexed page-zero base
            s_d.cyc = ST_DUMMY;
            s_d.bus = rd_cycle({`PAGE_ZERO, bus_din});
          end
          AM_IZY: begin
            s_d.ptr = bus_din;
            s_d.cyc = ST_PTR_LO;
            s_d.bus = rd_cycle({`PAGE_ZERO, bus_din});
          end
          default: begin
            // immediate operand is here; next opcode at pc+2
            s_d.opnd = bus_din;
            s_d.opnd_valid = 1'b1;
            s_d.cyc = ST_FETCH;
            s_d.bus = rd_cycle(pc_next);
          end
        endcase
      end
      ST_HIGH: begin
        s_d.pc = pc_next;
        s_d.hi = bus_din;
        if (mode == AM_ABX) begin
          // first try keeps the base page; carry saved for the fix-up
          s_d.carry = idx_carry;
          s_d.cyc = ST_INDEXED;
          s_d.bus = rd_cycle({bus_din, idx_sum});
        end else begin
          s_d.cyc = ST_DATA;
          s_d.bus = mem_cycle({bus_din, s_q.lo}, is_store,
                              wdata);
        end
      end
      ST_DUMMY: begin
        // page-zero sum drops the carry on purpose
        if (mode == AM_IZX) begin
          s_d.ptr = idx_sum;
          s_d.cyc = ST_PTR_LO;
          s_d.bus = rd_cycle({`PAGE_ZERO, idx_sum});
        end else begin
          s_d.cyc = ST_DATA;
          s_d.bus = mem_cycle({`PAGE_ZERO, idx_sum}, is_store,
                              wdata);
        end
      end
      ST_PTR_LO: begin
        // pointer high byte also wraps inside page zero
        s_d.lo = bus_din;
        s_d.cyc = ST_PTR_HI;
        s_d.bus = rd_cycle({`PAGE_ZERO, s_q.ptr + 8'h01});
      end
      ST_PTR_HI: begin
        s_d.hi = bus_din;
        if (mode == AM_IZY) begin
          s_d.carry = idx_carry;
          s_d.cyc = ST_INDEXED;
          s_d.bus = rd_cycle({bus_din, idx_sum});
        end else begin
          s_d.cyc = ST_DATA;
          s_d.bus = mem_cycle({bus_din, s_q.lo}, is_store,
                              wdata);
        end
      end
      ST_INDEXED: begin
        if (is_store) begin
          // stores never take the short path, carry or not
          s_d.cyc = ST_DATA;
          s_d.bus = mem_cycle({s_q.hi + {7'h00, s_q.carry},
                              s_q.bus.addr[7:0]}, 1'b1, wdata);
        end else if (s_q.carry) begin
          // data of this cycle came from the wrong page
          s_d.cyc = ST_DATA;
          s_d.bus = rd_cycle({s_q.hi + 8'h01,
                             s_q.bus.addr[7:0]});
        end else begin
          s_d.opnd = bus_din;
          s_d.opnd_valid = 1'b1;
          s_d.cyc = ST_FETCH;
          s_d.bus = rd_cycle(s_q.pc);
        end
      end
      ST_DATA: begin
        // reads hand the byte on while the next opcode is fetched
        if (!is_store) begin
          s_d.opnd = bus_din;
          s_d.opnd_valid = 1'b1;
        end
        s_d.cyc = ST_FETCH;
        s_d.bus = rd_cycle(s_q.pc);
      end
      default: begin
        s_d.cyc = ST_FETCH;
        s_d.bus = rd_cycle(s_q.pc);
      end
    endcase
  end

  // state register; first cycle after reset fetches at the reset pc
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.cyc <= ST_FETCH;
      s_q.pc <= `RESET_PC;
      s_q.opc <= `RESET_BYTE;
      s_q.lo <= `RESET_BYTE;
      s_q.hi <= `RESET_BYTE;
      s_q.ptr <= `RESET_BYTE;
      s_q.carry <= 1'b0;
      s_q.opnd <= `RESET_BYTE;
      s_q.opnd_valid <= 1'b0;
      s_q.bus.addr <= `RESET_PC;
      s_q.bus.rw <= 1'b1;
      s_q.bus.dout <= `RESET_DOUT;
      s_q.bus.doe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // all outputs come from the state register, opcode_fetch through a decode of its cycle field
  assign bus = s_q.bus;
  assign opcode_fetch = (s_q.cyc == ST_FETCH);
  assign operation_code = s_q.opc;
  assign operand_data = s_q.opnd;
  assign operand_valid = s_q.opnd_valid;

  // checks on the running sequence
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_abs_instr;
    s_q.cyc == ST_FETCH ##1
    (s_q.cyc == ST_OPND && mode == AM_ABS) ##1
    s_q.cyc == ST_HIGH ##1
    s_q.cyc == ST_DATA;
  endsequence

  sequence s_imm_instr;
    s_q.cyc == ST_FETCH ##1
    (s_q.cyc == ST_OPND && mode == AM_IMM);
  endsequence

  sequence s_zp_instr;
    (s_q.cyc == ST_OPND && mode == AM_ZP) ##1
    s_q.cyc == ST_DATA;
  endsequence

  fetch_at_pc_a: assert property (
    s_q.cyc == ST_FETCH |-> s_q.bus.rw && s_q.bus.addr == s_q.pc)
    else $error("opcode fetch not a read at pc");

  imm_two_cyc_a: assert property (
    s_imm_instr |=> s_q.cyc == ST_FETCH && operand_valid &&
      s_q.bus.addr == $past(s_q.bus.addr, 2) + 16'h0002)
    else $error("immediate form not two cycles at pc+2");

  zp_page_a: assert property (
    s_zp_instr |-> s_q.bus.addr[15:8] == 8'h00 &&
      s_q.bus.addr[7:0] == $past(bus_din))
    else $error("zero page access outside page zero");

  abs_len_a: assert property (
    s_abs_instr |=> s_q.cyc == ST_FETCH &&
      s_q.bus.addr == $past(s_q.bus.addr, 4) + `ABS_LEN)
    else $error("absolute form next fetch not at pc+3");

  ptr_page_zero_a: assert property (
    (s_q.cyc == ST_DUMMY || s_q.cyc == ST_PTR_LO ||
     s_q.cyc == ST_PTR_HI) |-> s_q.bus.rw && s_q.bus.addr[15:8] == 8'h00)
    else $error("pointer cycle left page zero");

  carry_fixup_a: assert property (
    (s_q.cyc == ST_INDEXED && !is_store && s_q.carry) |=>
      s_q.cyc == ST_DATA && !operand_valid && s_q.bus.rw &&
      s_q.bus.addr[15:8] == $past(s_q.bus.addr[15:8]) + 8'h01)
    else $error("page cross without next-page re-read");

  no_carry_short_a: assert property (
    (s_q.cyc == ST_INDEXED && !is_store && !s_q.carry) |=>
      s_q.cyc == ST_FETCH && operand_valid &&
      operand_data == $past(bus_din))
    else $error("no page cross but extra cycle taken");

  write_drive_a: assert property (
    (s_q.cyc == ST_DATA && is_store) |-> !s_q.bus.rw &&
      !s_q.bus.doe_n && s_q.bus.dout == $past(wdata))
    else $error("store final cycle not a driven write");

  store_no_overlap_a: assert property (
    (s_q.cyc == ST_DATA && is_store) |=> !operand_valid &&
      s_q.bus.rw && s_q.bus.doe_n)
    else $error("store overlapped with the next fetch");

  idx_store_full_a: assert property (
    (s_q.cyc == ST_INDEXED && is_store) |=>
      s_q.cyc == ST_DATA && !s_q.bus.rw)
    else $error("indexed store shortened");

  read_only_bus_a: assert property (
    s_q.cyc != ST_DATA |-> s_q.bus.rw && s_q.bus.doe_n)
    else $error("write outside final store cycle");

  data_overlap_a: assert property (
    (s_q.cyc == ST_DATA && !is_store) |=> s_q.cyc == ST_FETCH &&
      operand_valid && operand_data == $past(bus_din))
    else $error("read data not handed on during next fetch");

  // the sum must wrap inside page zero, never carry into the high byte
  zp_idx_wrap_a: assert property (
    (s_q.cyc == ST_DUMMY && mode == AM_ZPX) |=> s_q.cyc == ST_DATA &&
      s_q.bus.addr[15:8] == 8'h00 &&
      s_q.bus.addr[7:0] == 8'($past(s_q.bus.addr[7:0]) + $past(idx)))
    else $error("zero page index left page zero");

  zp_store_len_a: assert property (
    (s_q.cyc == ST_OPND && mode == AM_ZP && is_store) |=>
      (s_q.cyc == ST_DATA && !s_q.bus.rw) ##1 s_q.cyc == ST_FETCH)
    else $error("zero page store not three cycles");

endmodule : cpu_bus_cycle_sequencer

// ---- bus_memory.sv ----
// partner model: byte-wide system memory answering every bus cycle
// assumes the sequencer registers its bus outputs on core_clk rising edges
`timescale 1ns/1ps

module bus_memory
  import cpu_seq_pkg::*;
(
  input wire logic core_clk,
  input wire bus_t bus,
  output logic [7:0] bus_din
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q;

  // reads answer at once, discarded ones too; while the sequencer writes
  // nobody here drives the line, so show the inverse of the last byte read
  assign bus_din = bus.rw ? mem[bus.addr] : ~last_q;

  // capture every write cycle, remember the last byte read
  always @(posedge core_clk) begin
    if (!bus.rw) begin
      mem[bus.addr] <= bus.dout;
    end else begin
      last_q <= mem[bus.addr];
    end
  end
endmodule : bus_memory

// ---- cpu_bus_cycle_sequencer_tb_top.sv ----
// testbench for the bus cycle sequencer: a table of single instructions,
// then back-to-back instructions and a reset in mid-run
// assumes the memory model answers reads within the same cycle
`timescale 1ns/1ps
`include "cpu_seq_defs.svh"

module cpu_bus_cycle_sequencer_tb_top
  import cpu_seq_pkg::*;
;
  // one instruction: bytes, pointer pair, expected walk
  typedef struct packed {
    logic [7:0] opc, b1, b2;
    logic [15:0] ptr;
    logic [3:0] len;
    logic [15:0] ea, pre;
    logic [3:0] n;
  } row_t;
  // what the outputs showed in one cycle
  typedef struct packed {
    bus_t b;
    logic f, v;
    logic [7:0] oc, od;
  } snap_t;

  logic core_clk, rst_n, opcode_fetch, operand_valid;
  logic [7:0] bus_din, operation_code, operand_data, exp_v, wv, pa;
  core_regs_t regs;
  bus_t bus;
  snap_t tr [0:11];
  snap_t f, q, p;
  row_t rows [0:16];
  row_t r;
  int n, error_cnt, checks;

  cpu_bus_cycle_sequencer i_cpu_bus_cycle_sequencer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .bus_din(bus_din),
    .regs(regs),
    .bus(bus),
    .opcode_fetch(opcode_fetch),
    .operation_code(operation_code),
    .operand_data(operand_data),
    .operand_valid(operand_valid)
  );

  bus_memory i_bus_memory (
    .core_clk(core_clk),
    .bus(bus),
    .bus_din(bus_din)
  );

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // a hang ends the run through the same report
  initial begin
    #100000;
    err("run too long");
    print_verdict();
  end

  function automatic bit counted(input bit ok);
    checks++;
    return ok;
  endfunction : counted

  task automatic err(input string m);
    error_cnt++;
    $display("[ERR] %0t %s", $time, m);
  endtask : err

  // hold reset and refill memory with a known pattern
  task automatic prep();
    @(posedge core_clk);
    rst_n <= 1'b0;
    // refill only once reset holds the bus in read, so no write of the
    // running program lands on top of the fresh pattern
    @(negedge core_clk);
    for (int k = 0; k < 65536; k++) begin
      i_bus_memory.mem[k] = 8'(k ^ (k >> 8) ^ 8'h96);
    end
  endtask : prep

  // release after 16 cycles and record twelve cycles mid-period
  task automatic run_prog();
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int c = 0; c < 12; c++) begin
      @(negedge core_clk);
      tr[c] = '{bus, opcode_fetch, operand_valid, operation_code,
                operand_data};
    end
  endtask : run_prog

  task automatic print_verdict();
    $display("checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    rst_n = 1'b0;
    regs = '{8'h5a, 8'h14, 8'hc8};
    error_cnt = 0;
    checks = 0;
    // opcode, byte 1, byte 2, pointer, next pc, data addr, addr before, n
    rows = '{
      '{8'h00,8'h77,8'h00,16'h0000,4'h2,16'h0001,16'h0000,4'h2},
      '{8'h70,8'h33,8'h00,16'h0000,4'h2,16'h0001,16'h0000,4'h2},
      '{8'h10,8'h80,8'h00,16'h0000,4'h2,16'h0080,16'h0001,4'h3},
      '{8'h20,8'h34,8'h12,16'h0000,4'h3,16'h1234,16'h0002,4'h4},
      '{8'h30,8'hf0,8'h00,16'h4321,4'h2,16'h4321,16'h0005,4'h6},
      '{8'h40,8'h10,8'h22,16'h0000,4'h3,16'h2224,16'h0002,4'h4},
      '{8'h48,8'h50,8'h22,16'h0000,4'h3,16'h2318,16'h2218,4'h5},
      '{8'h58,8'h80,8'h00,16'h0000,4'h2,16'h0048,16'h0080,4'h4},
      '{8'h60,8'h40,8'h00,16'h3300,4'h2,16'h33c8,16'h0041,4'h5},
      '{8'h60,8'h60,8'h00,16'h3480,4'h2,16'h3548,16'h3448,4'h6},
      '{8'h93,8'h90,8'h00,16'h0000,4'h2,16'h0090,16'h0001,4'h3},
      '{8'ha1,8'h56,8'h45,16'h0000,4'h3,16'h4556,16'h0002,4'h4},
      '{8'hb2,8'h20,8'h00,16'h5678,4'h2,16'h5678,16'h0035,4'h6},
      '{8'hc0,8'h10,8'h66,16'h0000,4'h3,16'h6624,16'h6624,4'h5},
      '{8'hc8,8'h50,8'h22,16'h0000,4'h3,16'h2318,16'h2218,4'h5},
      '{8'hd1,8'h70,8'h00,16'h0000,4'h2,16'h0084,16'h0070,4'h4},
      '{8'he2,8'h50,8'h00,16'h7700,4'h2,16'h77c8,16'h77c8,4'h6}
    };
    // one instruction per row, each from a fresh reset at address 0000
    for (int i = 0; i < 17; i++) begin
      r = rows[i];
      prep();
      i_bus_memory.mem[0] = r.opc;
      i_bus_memory.mem[1] = r.b1;
      i_bus_memory.mem[2] = r.b2;
      // pointer pairs only where used, so page-zero data stays intact
      if (r.opc[6:4] == `MODE_IZX || r.opc[6:4] == `MODE_IZY) begin
        pa = (r.opc[6:4] == `MODE_IZX) ? r.b1 + regs.x : r.b1;
        i_bus_memory.mem[pa] = r.ptr[7:0];
        i_bus_memory.mem[8'(pa + 8'h01)] = r.ptr[15:8];
      end
      exp_v = i_bus_memory.mem[r.ea];
      wv = (r.opc[1:0] == `REG_SEL_X) ? regs.x :
           (r.opc[1:0] == `REG_SEL_Y) ? regs.y : regs.a;
      run_prog();
      n = 0;
      for (int c = 7; c > 0; c--) begin
        if (tr[c].f === 1'b1) begin
          n = c;
        end
      end
      f = tr[n];
      q = tr[n - 1];
      p = tr[n - 2];
      if (!counted(tr[0].b.addr === 16'h0000)) err("first fetch");
      if (!counted(tr[1].oc === r.opc)) err("opcode");
      if (!counted(n === r.n)) err("cycle count");
      if (!counted(f.b.addr === {12'h000, r.len})) err("next pc");
      if (!counted(q.b.addr === r.ea)) err("data address");
      if (!counted(q.b.rw === ~r.opc[7])) err("direction");
      if (!counted(p.b.addr === r.pre)) err("prior address");
      if (r.opc[7]) begin
        if (!counted(q.b.dout === wv)) err("write data");
        if (!counted(q.b.doe_n === 1'b0)) err("data enable");
        if (!counted(f.v === 1'b0)) err("store overlap");
      end else begin
        if (!counted(f.v === 1'b1)) err("no overlap");
        if (!counted(f.od === exp_v)) err("read data");
      end
      $display("row %0d done", i);
    end
    // zero-page read straight followed by an absolute store
    prep();
    i_bus_memory.mem[0] = 8'h10;
    i_bus_memory.mem[1] = 8'h80;
    i_bus_memory.mem[2] = 8'ha1;
    i_bus_memory.mem[3] = 8'h56;
    i_bus_memory.mem[4] = 8'h45;
    exp_v = i_bus_memory.mem[16'h0080];
    run_prog();
    if (!counted(tr[3].b.addr === 16'h0002)) err("second fetch");
    if (!counted(tr[3].od === exp_v)) err("overlap data");
    if (!counted(tr[6].b.dout === regs.x)) err("store data");
    if (!counted(tr[7].b.addr === 16'h0005)) err("third fetch");
    if (!counted(tr[7].v === 1'b0)) err("store overlap");
    $display("back-to-back done");
    // reset taken in mid-run acts at once, without a clock edge
    @(posedge core_clk);
    rst_n <= 1'b0;
    #1;
    if (!counted(bus.addr === 16'h0000)) err("reset addr");
    if (!counted(bus.rw === 1'b1)) err("reset rw");
    if (!counted(bus.dout === 8'h00)) err("reset dout");
    if (!counted(bus.doe_n === 1'b1)) err("reset enable");
    if (!counted(opcode_fetch === 1'b1)) err("fetch in reset");
    if (!counted(operation_code === 8'h00)) err("opcode in reset");
    if (!counted(operand_valid === 1'b0)) err("valid in reset");
    if (!counted(operand_data === 8'h00)) err("data in reset");
    $display("reset done");
    // second release: a store opcode in immediate mode runs as a read
    prep();
    i_bus_memory.mem[0] = 8'h80;
    i_bus_memory.mem[1] = 8'h77;
    run_prog();
    if (!counted(tr[0].b.addr === 16'h0000)) err("restart fetch");
    if (!counted(tr[1].oc === 8'h80)) err("restart opcode");
    if (!counted(tr[1].b.rw === 1'b1)) err("restart read");
    if (!counted(tr[2].v === 1'b1)) err("restart valid");
    if (!counted(tr[2].od === 8'h77)) err("restart data");
    $display("restart done");
    print_verdict();
  end
endmodule : cpu_bus_cycle_sequencer_tb_top
